// File: rtl/bank_timing_trim_and_timestamp_ctrl.sv
// Functional notes
// - Bank0 neg90 trim used in single-channel mode
// - Bank1 zero trim used in dual-channel mode
// - Bank1 neg90 trim used in single-channel mode
// - Bank4 zero trim used in both modes
// - Bank5 zero trim used in both modes
// - Trims load from fuses, stay read-write
// - Enable bit puts stamp on sample LSB
// - Stamp delayed same as sample latency
// - Stamp control resets to zero, reserved RW
// - Stamp rides lane 0 regardless width
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "trim_regs.svh"
module bank_timing_trim_and_timestamp_ctrl
	import trim_pkg::*;
#(
	parameter int LATENCY = `SAMPLE_LATENCY,
	parameter int WIDTH   = 12
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	input  wire logic [11:0]       addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	input  wire logic [39:0]       fuse_bits_i,
	input  wire logic              single_mode_i,
	input  wire logic              stamp_receiver_enable_i,
	input  wire logic              stamp_i,
	input  wire logic [WIDTH-1:0]  sample_i,
	output logic      [WIDTH-1:0]  sample_o,
	output logic      [7:0]        conv_a_bank0_trim_o,
	output logic      [7:0]        conv_a_bank1_trim_o,
	output logic      [7:0]        conv_b_bank4_trim_o,
	output logic      [7:0]        conv_b_bank5_trim_o,
	output logic                   trim_ready_o
);
	initial begin
		if (LATENCY < 2) $error("LATENCY must be at least 2");
		if (WIDTH < 2) $error("WIDTH must be at least 2");
	end

	// Reset release through two flops
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	trim_t       bank0_trim_neg90;
	trim_t       bank1_trim_zero;
	trim_t       bank1_trim_neg90;
	trim_t       bank4_trim_zero;
	trim_t       bank5_trim_zero;
	logic [7:0]  stamp_output_control;
	load_state_t state;
	logic [2:0]  load_idx;
	logic [2:0]  cap_idx;
	logic        cap_valid;

	fuse_if fuse ();

	fuse_store #(
		.DEPTH(5)
	) u_fuse (
		.clk_i       (sys_clk_i),
		.rst_n_i     (rst_n),
		.fuse_bits_i (fuse_bits_i),
		.port        (fuse.store)
	);

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
		return a == ref_a;
	endfunction

	// Fuse load walks every trim once after reset
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state     <= LOAD_IDLE;
			load_idx  <= 3'h0;
			cap_idx   <= 3'h0;
			cap_valid <= 1'b0;
		end else begin
			cap_valid <= 1'b0;
			case (state)
			LOAD_IDLE: begin
				state <= LOAD_READ;
			end
			LOAD_READ: begin
				cap_idx   <= load_idx;
				cap_valid <= 1'b1;
				if (load_idx == `FUSE_COUNT - 3'h1) begin
					state <= LOAD_DONE;
				end else begin
					load_idx <= load_idx + 3'h1;
				end
			end
			LOAD_DONE: begin
				state <= LOAD_DONE;
			end
			default: begin
				state <= LOAD_IDLE;
			end
			endcase
		end
	end
	assign fuse.rd_en   = (state == LOAD_READ);
	assign fuse.rd_addr = load_idx;

	// Trims: fuse value first, software may override later; fuse load wins during load
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bank0_trim_neg90 <= 8'h00;
			bank1_trim_zero  <= 8'h00;
			bank1_trim_neg90 <= 8'h00;
			bank4_trim_zero  <= 8'h00;
			bank5_trim_zero  <= 8'h00;
		end else if (cap_valid) begin
			case (cap_idx)
			`FUSE_INDEX_BANK0_NEG90: bank0_trim_neg90 <= fuse.rd_data;
			`FUSE_INDEX_BANK1_ZERO:  bank1_trim_zero  <= fuse.rd_data;
			`FUSE_INDEX_BANK1_NEG90: bank1_trim_neg90 <= fuse.rd_data;
			`FUSE_INDEX_BANK4_ZERO:  bank4_trim_zero  <= fuse.rd_data;
			`FUSE_INDEX_BANK5_ZERO:  bank5_trim_zero  <= fuse.rd_data;
			default: begin
			end
			endcase
		end else if (wr_i) begin
			if (hit(addr_i, `ADDR_BANK0_TRIM_NEG90)) bank0_trim_neg90 <= wdata_i;
			if (hit(addr_i, `ADDR_BANK1_TRIM_ZERO))  bank1_trim_zero  <= wdata_i;
			if (hit(addr_i, `ADDR_BANK1_TRIM_NEG90)) bank1_trim_neg90 <= wdata_i;
			if (hit(addr_i, `ADDR_BANK4_TRIM_ZERO))  bank4_trim_zero  <= wdata_i;
			if (hit(addr_i, `ADDR_BANK5_TRIM_ZERO))  bank5_trim_zero  <= wdata_i;
		end
	end

	// Stamp control, all bits stored, reserved ones too
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stamp_output_control <= `STAMP_CTRL_RESET;
		end else if (wr_i && hit(addr_i, `ADDR_STAMP_CTRL)) begin
			stamp_output_control <= wdata_i;
		end
	end

	// Read port, unmapped addresses read zero
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
			`ADDR_BANK0_TRIM_NEG90: rdata_o <= bank0_trim_neg90;
			`ADDR_BANK1_TRIM_ZERO:  rdata_o <= bank1_trim_zero;
			`ADDR_BANK1_TRIM_NEG90: rdata_o <= bank1_trim_neg90;
			`ADDR_BANK4_TRIM_ZERO:  rdata_o <= bank4_trim_zero;
			`ADDR_BANK5_TRIM_ZERO:  rdata_o <= bank5_trim_zero;
			`ADDR_STAMP_CTRL:       rdata_o <= stamp_output_control;
			`ADDR_TRIM_STATUS:      rdata_o <= {7'h00, state == LOAD_DONE};
			default:                rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Trim selection by clock phase; bank 0 zero-degree trim lives elsewhere
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			conv_a_bank0_trim_o <= 8'h00;
			conv_a_bank1_trim_o <= 8'h00;
			conv_b_bank4_trim_o <= 8'h00;
			conv_b_bank5_trim_o <= 8'h00;
			trim_ready_o        <= 1'b0;
		end else begin
			conv_a_bank0_trim_o <= single_mode_i ? bank0_trim_neg90 : 8'h00;
			conv_a_bank1_trim_o <= single_mode_i ? bank1_trim_neg90
			                                     : bank1_trim_zero;
			conv_b_bank4_trim_o <= bank4_trim_zero;
			conv_b_bank5_trim_o <= bank5_trim_zero;
			trim_ready_o        <= (state == LOAD_DONE);
		end
	end

	// Sample path and stamp path share one latency
	logic             stamp_gated;
	logic             stamp_late;
	logic [WIDTH-1:0] sample_pipe [LATENCY-1];
	assign stamp_gated = stamp_i & stamp_receiver_enable_i;

	stamp_delay #(
		.LATENCY(LATENCY - 1)
	) u_delay (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.in_i    (stamp_gated),
		.out_o   (stamp_late)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LATENCY - 1; i++) sample_pipe[i] <= '0;
		end else begin
			sample_pipe[0] <= sample_i;
			for (int i = 1; i < LATENCY - 1; i++) sample_pipe[i] <= sample_pipe[i-1];
		end
	end

	// Last stage: lane 0 carries the stamp when enabled
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sample_o <= '0;
		end else if (stamp_output_control[`STAMP_EN_BIT]) begin
			sample_o <= {sample_pipe[LATENCY-2][WIDTH-1:1], stamp_late};
		end else begin
			sample_o <= sample_pipe[LATENCY-2];
		end
	end

	property p_stamp_ctrl_reset;
		@(posedge sys_clk_i) $rose(rst_n) |-> stamp_output_control == 8'h00;
	endproperty
	a_stamp_ctrl_reset: assert property (p_stamp_ctrl_reset) else $error("ctrl not zero");

	property p_stamp_lsb;
		@(posedge sys_clk_i) disable iff (!rst_n)
		stamp_output_control[0] && $past(stamp_output_control[0])
		|=> sample_o[0] == $past(stamp_late);
	endproperty
	a_stamp_lsb: assert property (p_stamp_lsb) else $error("stamp not on lsb");

	property p_latency;
		@(posedge sys_clk_i) disable iff (!rst_n)
		$past(stamp_output_control[0]) |-> sample_o[0] == $past(stamp_gated, LATENCY);
	endproperty
	a_latency: assert property (p_latency) else $error("latency check");

	property p_bank4;
		@(posedge sys_clk_i) disable iff (!rst_n)
		1'b1 |=> conv_b_bank4_trim_o == $past(bank4_trim_zero);
	endproperty
	a_bank4: assert property (p_bank4) else $error("bank4 trim");

	property p_bank5;
		@(posedge sys_clk_i) disable iff (!rst_n)
		1'b1 |=> conv_b_bank5_trim_o == $past(bank5_trim_zero);
	endproperty
	a_bank5: assert property (p_bank5) else $error("bank5 trim");

	property p_bank1_zero;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!single_mode_i |=> conv_a_bank1_trim_o == $past(bank1_trim_zero);
	endproperty
	a_bank1_zero: assert property (p_bank1_zero) else $error("bank1 zero");

	property p_bank1_neg;
		@(posedge sys_clk_i) disable iff (!rst_n)
		single_mode_i |=> conv_a_bank1_trim_o == $past(bank1_trim_neg90);
	endproperty
	a_bank1_neg: assert property (p_bank1_neg) else $error("bank1 neg90");

	property p_bank0_neg;
		@(posedge sys_clk_i) disable iff (!rst_n)
		single_mode_i |=> conv_a_bank0_trim_o == $past(bank0_trim_neg90);
	endproperty
	a_bank0_neg: assert property (p_bank0_neg) else $error("bank0 neg90");

	property p_fuse_load;
		@(posedge sys_clk_i) disable iff (!rst_n)
		$rose(rst_n) ##0 1'b1 |-> ##[1:12] trim_ready_o;
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("fuse load slow");

	// Data bits above the stamp lane keep the full pipeline depth
	property p_sample_delay;
		@(posedge sys_clk_i) disable iff (!rst_n)
		$past(rst_n, LATENCY) |-> sample_o[WIDTH-1:1] == $past(sample_i[WIDTH-1:1], LATENCY);
	endproperty
	a_sample_delay: assert property (p_sample_delay) else $error("sample latency");

	// Dual mode has no use for the neg90 bank 0 trim
	property p_bank0_dual;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!single_mode_i |=> conv_a_bank0_trim_o == 8'h00;
	endproperty
	a_bank0_dual: assert property (p_bank0_dual) else $error("bank0 dual");

	// Every bit of the control word lands, reserved ones too
	property p_ctrl_write;
		@(posedge sys_clk_i) disable iff (!rst_n)
		wr_i && addr_i == `ADDR_STAMP_CTRL |=> stamp_output_control == $past(wdata_i);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write");
endmodule
`default_nettype wire

// File: include/trim_regs.svh
`ifndef TRIM_REGS_SVH
`define TRIM_REGS_SVH
`define ADDR_BANK0_TRIM_NEG90  12'h103
`define ADDR_BANK1_TRIM_ZERO   12'h112
`define ADDR_BANK1_TRIM_NEG90  12'h113
`define ADDR_BANK4_TRIM_ZERO   12'h142
`define ADDR_BANK5_TRIM_ZERO   12'h152
`define ADDR_STAMP_CTRL        12'h160
`define ADDR_TRIM_STATUS       12'h170
`define STAMP_EN_BIT           0
`define STAMP_CTRL_RESET       8'h00
`define FUSE_INDEX_BANK0_NEG90 3'h0
`define FUSE_INDEX_BANK1_ZERO  3'h1
`define FUSE_INDEX_BANK1_NEG90 3'h2
`define FUSE_INDEX_BANK4_ZERO  3'h3
`define FUSE_INDEX_BANK5_ZERO  3'h4
`define FUSE_COUNT             3'h5
`define SAMPLE_LATENCY         4
`endif

// File: include/trim_pkg.sv
package trim_pkg;
	typedef enum logic [1:0] {
		LOAD_IDLE,
		LOAD_READ,
		LOAD_DONE
	} load_state_t;
	typedef logic [7:0] trim_t;
endpackage

// File: include/fuse_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fuse_if;
	logic       rd_en;
	logic [2:0] rd_addr;
	logic [7:0] rd_data;
	modport requester (output rd_en, output rd_addr, input rd_data);
	modport store (input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: rtl/fuse_store.sv
`timescale 1ns/1ps
`default_nettype none
module fuse_store
	import trim_pkg::*;
#(
	parameter int DEPTH = 5
) (
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	input  wire logic [8*DEPTH-1:0] fuse_bits_i,
	fuse_if.store       port
);
	initial begin
		if (DEPTH < 1 || DEPTH > 8) $error("fuse_store: DEPTH out of range");
	end
	// Registered read so the load sequence sees one-cycle latency
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port.rd_data <= 8'h00;
		end else if (port.rd_en) begin
			port.rd_data <= fuse_bits_i[port.rd_addr*8 +: 8];
		end
	end
endmodule
`default_nettype wire

// File: rtl/stamp_delay.sv
`timescale 1ns/1ps
`default_nettype none
module stamp_delay #(
	parameter int LATENCY = 4
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic in_i,
	output logic      out_o
);
	logic [LATENCY-1:0] pipe;
	initial begin
		if (LATENCY < 1) $error("stamp_delay: LATENCY must be at least 1");
	end
	// Shift line matched to the sample pipeline depth
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pipe <= '0;
		end else begin
			// Cast drops the oldest bit, which also serves a one-stage line
			pipe <= LATENCY'({pipe, in_i});
		end
	end
	assign out_o = pipe[LATENCY-1];
endmodule
`default_nettype wire

// File: verif/bank_timing_trim_and_timestamp_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "trim_regs.svh"
module bank_timing_trim_and_timestamp_ctrl_bench;
	import trim_pkg::*;
	localparam logic [39:0] FUSE = 40'h5A_C3_3C_A5_96;
	localparam logic [39:0] FUSE_ALT = 40'h1E_2D_4B_87_F0;
	localparam logic [11:0] ADDR [5] = '{`ADDR_BANK0_TRIM_NEG90, `ADDR_BANK1_TRIM_ZERO,
		`ADDR_BANK1_TRIM_NEG90, `ADDR_BANK4_TRIM_ZERO, `ADDR_BANK5_TRIM_ZERO};
	logic        sys_clk_i;
	logic        rstn_i;
	logic [11:0] addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        single_mode_i;
	logic        stamp_receiver_enable_i;
	logic        stamp_i;
	logic [11:0] sample_i;
	logic [11:0] sample_o;
	logic [7:0]  a0;
	logic [7:0]  a1;
	logic [7:0]  b4;
	logic [7:0]  b5;
	logic        trim_ready_o;
	logic [39:0] fuse_bits;
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	bank_timing_trim_and_timestamp_ctrl #(.LATENCY(`SAMPLE_LATENCY), .WIDTH(12)) dut_u (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fuse_bits_i(fuse_bits),
		.single_mode_i(single_mode_i), .stamp_receiver_enable_i(stamp_receiver_enable_i),
		.stamp_i(stamp_i), .sample_i(sample_i), .sample_o(sample_o),
		.conv_a_bank0_trim_o(a0), .conv_a_bank1_trim_o(a1), .conv_b_bank4_trim_o(b4),
		.conv_b_bank5_trim_o(b5), .trim_ready_o(trim_ready_o));

	// 200 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Master strobes are one cycle, launched just after an edge
	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// Fuse load finishes within a bounded number of cycles
	task automatic wait_ready();
		for (int k = 0; k < 200 && trim_ready_o !== 1'b1; k++)
			@(posedge sys_clk_i);
		check("load done", {11'h000, trim_ready_o}, 12'h001);
	endtask

	task automatic t_load(input logic [39:0] v);
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			reg_rd(ADDR[i], d);
			check("fuse trim", {4'h0, d}, {4'h0, v[8*i +: 8]});
		end
		reg_rd(`ADDR_STAMP_CTRL, d);
		check("ctrl reset", {4'h0, d}, 12'h000);
		reg_rd(`ADDR_TRIM_STATUS, d);
		check("load status", {4'h0, d}, 12'h001);
		reg_rd(12'h104, d);
		check("unmapped read", {4'h0, d}, 12'h000);
		$display("test load done");
	endtask

	// Phase select follows the channel mode; second converter ignores it
	task automatic t_modes(input logic [39:0] v);
		@(posedge sys_clk_i);
		single_mode_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#1 check("a0 single", {4'h0, a0}, {4'h0, v[7:0]});
		check("a1 single", {4'h0, a1}, {4'h0, v[23:16]});
		check("b4 single", {4'h0, b4}, {4'h0, v[31:24]});
		check("b5 single", {4'h0, b5}, {4'h0, v[39:32]});
		@(posedge sys_clk_i);
		single_mode_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1 check("a0 dual", {4'h0, a0}, 12'h000);
		check("a1 dual", {4'h0, a1}, {4'h0, v[15:8]});
		check("b4 dual", {4'h0, b4}, {4'h0, v[31:24]});
		check("b5 dual", {4'h0, b5}, {4'h0, v[39:32]});
		$display("test modes done");
	endtask

	task automatic t_write();
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			reg_wr(ADDR[i], ~FUSE[8*i +: 8]);
			reg_rd(ADDR[i], d);
			check("trim write", {4'h0, d}, {4'h0, ~FUSE[8*i +: 8]});
		end
		reg_wr(12'h104, 8'h77);
		reg_rd(`ADDR_BANK0_TRIM_NEG90, d);
		check("unmapped write", {4'h0, d}, {4'h0, ~FUSE[7:0]});
		reg_wr(`ADDR_STAMP_CTRL, 8'hFE);
		reg_rd(`ADDR_STAMP_CTRL, d);
		check("ctrl reserved", {4'h0, d}, 12'h0FE);
		$display("test write done");
	endtask

	// Stamp must come out in the same cycle as the sample it marks
	// Without the receiver enable no stamp reaches the output
	task automatic t_stamp(input logic en, input logic rx);
		logic [12:0] h [$];
		logic [11:0] s;
		reg_wr(`ADDR_STAMP_CTRL, {7'h00, en});
		stamp_receiver_enable_i <= rx;
		for (int j = 0; j < 20; j++) begin
			@(posedge sys_clk_i);
			s = 12'(j * 331 + 1);
			sample_i <= s;
			stamp_i <= (j % 3 == 0);
			h.push_back({(j % 3 == 0) & rx, s});
			#1;
			if (j >= `SAMPLE_LATENCY)
				check("sample out", sample_o, en ? {h[j-4][11:1], h[j-4][12]} : h[j-4][11:0]);
		end
		$display("test stamp done");
	endtask

	// Mid-run reset clears control and reloads trims from new fuse content
	task automatic t_reset(input logic [39:0] f);
		@(posedge sys_clk_i);
		fuse_bits <= f;
		rstn_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1 check("sample in reset", sample_o, 12'h000);
		check("ready in reset", {11'h000, trim_ready_o}, 12'h000);
		@(posedge sys_clk_i);
		rstn_i <= 1'b1;
		wait_ready();
		t_load(f);
		$display("test reset done");
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		rstn_i = 1'b0;
		fuse_bits = FUSE;
		addr_i = 12'h000;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		single_mode_i = 1'b0;
		stamp_receiver_enable_i = 1'b0;
		stamp_i = 1'b0;
		sample_i = 12'h000;
		repeat (3) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		wait_ready();
		t_load(FUSE);
		t_modes(FUSE);
		t_write();
		t_modes(~FUSE);
		t_stamp(1'b0, 1'b1);
		t_stamp(1'b1, 1'b1);
		t_stamp(1'b1, 1'b0);
		t_reset(FUSE_ALT);
		t_modes(FUSE_ALT);
		finish_test();
	end
endmodule
`default_nettype wire
